// ---- verilog/rlpm_consts.svh ----
// Constants for the regulator LIN frame payload map
`ifndef RLPM_CONSTS_SVH
`define RLPM_CONSTS_SVH
// Frame identifiers
`define RLPM_ID_CTRL_A     6'h29
`define RLPM_ID_CTRL_B     6'h2A
`define RLPM_ID_STAT_A     6'h11
`define RLPM_ID_IDENT_A    6'h12
`define RLPM_ID_STAT_B     6'h13
`define RLPM_ID_IDENT_B    6'h14
// Payload lengths
`define RLPM_CTRL_BYTES    3'h4
`define RLPM_RESP_BYTES    2'h2
// Control payload fields
`define RLPM_TV_HI         5
`define RLPM_RC_HI         7
`define RLPM_RC_LO         4
`define RLPM_RR_HI         3
`define RLPM_CL_HI         4
`define RLPM_TV_SHUTDOWN   6'h00
// Measurement full scale
`define RLPM_MEAS_FULL     8'h3F
// Register addresses
`define RLPM_A_IRQ_STAT    4'h0
`define RLPM_A_IRQ_MASK    4'h1
`define RLPM_A_CFG         4'h2
`define RLPM_A_TV          4'h3
`define RLPM_A_RAMP        4'h4
`define RLPM_A_CLIM        4'h5
// Interrupt bits
`define RLPM_EV_ACCEPT     0
`define RLPM_EV_REJECT     1
`define RLPM_EV_SHUTDOWN   2
`define RLPM_EV_SENT       3
// Configuration bits and reset values
`define RLPM_CFG_ALT_B     0
`define RLPM_CFG_TEMP      1
`define RLPM_CFG_RST       8'h00
`define RLPM_MASK_RST      8'h00
`endif

// ---- verilog/rlpm_pkg.sv ----
// Types and frame decode for the regulator LIN frame payload map
`include "rlpm_consts.svh"
package rlpm_pkg;
    typedef enum logic [1:0] {RLPM_K_NONE, RLPM_K_CTRL, RLPM_K_STAT, RLPM_K_IDENT} rlpm_kind_t;

    // Sort a frame identifier for alternator A or B
    function automatic rlpm_kind_t rlpm_classify(input logic [5:0] id, input logic altB);
        rlpm_kind_t k;
        k = RLPM_K_NONE;
        if (id == (altB ? `RLPM_ID_CTRL_B : `RLPM_ID_CTRL_A))
            k = RLPM_K_CTRL;
        else if (id == (altB ? `RLPM_ID_STAT_B : `RLPM_ID_STAT_A))
            k = RLPM_K_STAT;
        else if (id == (altB ? `RLPM_ID_IDENT_B : `RLPM_ID_IDENT_A))
            k = RLPM_K_IDENT;
        return k;
    endfunction : rlpm_classify
endpackage : rlpm_pkg

// ---- verilog/rlpm_resp_pack.sv ----
// Packs the two-byte status and identifier responses
`timescale 1ns/1ps
`default_nettype none
module rlpm_resp_pack
    import rlpm_pkg::*;
(
    input  wire rlpm_kind_t  kind,
    input  wire logic        byteIdx,
    input  wire logic [4:0]  dutyCycle,
    input  wire logic        elFault,
    input  wire logic        mecFault,
    input  wire logic        hotFault,
    input  wire logic        busTimeout,
    input  wire logic        comError,
    input  wire logic [5:0]  measField,
    input  wire logic [4:0]  classCode,
    input  wire logic [2:0]  mfrCode,
    input  wire logic        slaveNoResp,
    input  wire logic        checksumFault,
    input  wire logic        idParityFault,
    input  wire logic        syncBreakFault,
    output logic      [7:0]  respByte
);
    // Byte layout by frame kind and position
    always_comb
    begin
        respByte = 8'h00;
        unique case (kind)
            RLPM_K_STAT:
                respByte = byteIdx ? {busTimeout, comError, measField} // RULE8
                                   : {dutyCycle, elFault, mecFault, hotFault}; // RULE7
            RLPM_K_IDENT:
                respByte = byteIdx ? {4'h0, slaveNoResp, checksumFault, idParityFault,
                                      syncBreakFault} // RULE11
                                   : {classCode, mfrCode}; // RULE10
            RLPM_K_CTRL,
            RLPM_K_NONE:
                respByte = 8'h00;
        endcase
    end
endmodule : rlpm_resp_pack
`default_nettype wire

// ---- verilog/rlpm_payload_map.sv ----
// LIN data-field decoder and response packer of the alternator regulator
// Summary of operation
// [RULE1] Identifier 29 carries four master-to-regulator control bytes for alternator A.
// [RULE2] Identifier 2A carries the same control layout for alternator B.
// [RULE3] Control byte 1 low six bits are target voltage; top two bits ignored.
// [RULE4] Control byte 2 upper nibble is setting_a, lower nibble ramp rate.
// [RULE5] Control byte 3 low five bits are current limit; rest and byte 4 ignored.
// [RULE6] Identifier 11 is a two-byte status response for alternator A.
// [RULE7] Status byte 1: duty cycle 7..3, electrical 2, mechanical 1, over-temperature 0.
// [RULE8] Status byte 2: timeout bit 7, com error bit 6, measurement bits 5..0.
// [RULE9] Identifier 12 is a two-byte identifier response for alternator A.
// [RULE10] Identifier byte 1: class code 7..3, manufacturer code 2..0 from settings.
// [RULE11] Identifier byte 2: zeros on top, four link fault flags below.
// [RULE12] Control frames only received; status and identifier frames only sent.
// [RULE13] Pre-excitation only after an own control frame; zero voltage code shuts down.
// [RULE14] Measurement is current or temperature; current clamps at full scale.
// [RULE15] Settings update only on an error-free complete own control frame.
`timescale 1ns/1ps
`default_nettype none
module rlpm_payload_map
    import rlpm_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        frmStart,
    input  wire logic [5:0]  frmId,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxByte,
    input  wire logic        frmDone,
    input  wire logic        frmChkErr,
    input  wire logic        frmParErr,
    input  wire logic        txReq,
    input  wire logic [4:0]  excitation_duty_cycle,
    input  wire logic        electrical_fault_flag,
    input  wire logic        mechanical_fault_flag,
    input  wire logic        over_temperature_flag,
    input  wire logic        busTimeout,
    input  wire logic        comError,
    input  wire logic [7:0]  measCurrent,
    input  wire logic [5:0]  measTemp,
    input  wire logic [4:0]  classCode,
    input  wire logic [2:0]  mfrCode,
    input  wire logic        slaveNoResp,
    input  wire logic        checksumFault,
    input  wire logic        idParityFault,
    input  wire logic        syncBreakFault,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  txByte,
    output logic             txValid,
    output logic      [5:0]  targetVoltage,
    output logic      [3:0]  setting_a,
    output logic      [3:0]  load_response_control,
    output logic      [4:0]  currentLimit,
    output logic             preExcEnable,
    output logic             shutdownCmd,
    output logic      [7:0]  regRdata,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    rlpm_kind_t  kind_ff, nxt_kind;
    logic [2:0]  rxCnt_ff, nxt_rxCnt;
    logic [7:0]  rxBuf_ff [0:3];
    logic [7:0]  nxt_rxBuf [0:3];
    logic [5:0]  tv_ff, nxt_tv;
    logic [3:0]  rc_ff, nxt_rc;
    logic [3:0]  rr_ff, nxt_rr;
    logic [4:0]  cl_ff, nxt_cl;
    logic        preExc_ff, nxt_preExc;
    logic        shut_ff, nxt_shut;
    logic [1:0]  txIdx_ff, nxt_txIdx;
    logic [7:0]  txByte_ff, nxt_txByte;
    logic        txValid_ff, nxt_txValid;
    logic [7:0]  stat_ff, nxt_stat;
    logic [7:0]  mask_ff, nxt_mask;
    logic [7:0]  cfg_ff, nxt_cfg;
    logic [7:0]  rdData_ff, nxt_rdData;
    logic        irq_ff, nxt_irq;
    logic        ctrlOk;
    logic        ctrlBad;
    logic        evSent;
    logic [7:0]  events;
    logic [7:0]  respByte;
    logic [5:0]  measField;

    ////////////////////////////////////////////////////////////////////////////
    // Frame acceptance; a short or errored frame leaves the settings alone
    assign ctrlOk  = frmDone && kind_ff == RLPM_K_CTRL && rxCnt_ff == `RLPM_CTRL_BYTES
                     && !frmChkErr && !frmParErr; // RULE15
    assign ctrlBad = frmDone && kind_ff == RLPM_K_CTRL && !ctrlOk;

    // Frame sorting, control byte capture and setting decode
    always_comb
    begin
        nxt_kind   = kind_ff;
        nxt_rxCnt  = rxCnt_ff;
        nxt_rxBuf  = rxBuf_ff;
        nxt_tv     = tv_ff;
        nxt_rc     = rc_ff;
        nxt_rr     = rr_ff;
        nxt_cl     = cl_ff;
        nxt_preExc = preExc_ff;
        nxt_shut   = shut_ff;
        if (frmStart)
        begin
            nxt_kind  = rlpm_classify(frmId, cfg_ff[`RLPM_CFG_ALT_B]); // RULE1 RULE2 RULE6 RULE9
            nxt_rxCnt = 3'h0;
        end
        else if (rxValid && kind_ff == RLPM_K_CTRL && rxCnt_ff < `RLPM_CTRL_BYTES)
        begin
            // Extra bytes past the fourth are dropped
            nxt_rxBuf[rxCnt_ff[1:0]] = rxByte;
            nxt_rxCnt = rxCnt_ff + 3'h1;
        end
        if (ctrlOk)
        begin
            nxt_tv = rxBuf_ff[0][`RLPM_TV_HI:0]; // RULE3
            nxt_rc = rxBuf_ff[1][`RLPM_RC_HI:`RLPM_RC_LO]; // RULE4
            nxt_rr = rxBuf_ff[1][`RLPM_RR_HI:0]; // RULE4
            nxt_cl = rxBuf_ff[2][`RLPM_CL_HI:0]; // RULE5
            // Zero code doubles as shutdown, not the lowest set point
            nxt_shut   = rxBuf_ff[0][`RLPM_TV_HI:0] == `RLPM_TV_SHUTDOWN; // RULE13
            nxt_preExc = !nxt_shut; // RULE13
        end
        if (frmDone && !frmStart)
            nxt_kind = RLPM_K_NONE;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_ff   <= RLPM_K_NONE;
            rxCnt_ff  <= 3'h0;
            tv_ff     <= 6'h00;
            rc_ff     <= 4'h0;
            rr_ff     <= 4'h0;
            cl_ff     <= 5'h00;
            preExc_ff <= 1'b0;
            shut_ff   <= 1'b0;
        end
        else
        begin
            kind_ff   <= nxt_kind;
            rxCnt_ff  <= nxt_rxCnt;
            tv_ff     <= nxt_tv;
            rc_ff     <= nxt_rc;
            rr_ff     <= nxt_rr;
            cl_ff     <= nxt_cl;
            preExc_ff <= nxt_preExc;
            shut_ff   <= nxt_shut;
        end
    end

    // Control byte buffer, one register per byte position
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_rxBuf
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    rxBuf_ff[g] <= 8'h00;
                else
                    rxBuf_ff[g] <= nxt_rxBuf[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Measurement field: current saturates, temperature passes through
    assign measField = cfg_ff[`RLPM_CFG_TEMP] ? measTemp
                     : (measCurrent > `RLPM_MEAS_FULL ? 6'(`RLPM_MEAS_FULL)
                                                      : measCurrent[5:0]); // RULE14

    rlpm_resp_pack u_pack (
        .kind           (kind_ff),
        .byteIdx        (txIdx_ff[0]),
        .dutyCycle      (excitation_duty_cycle),
        .elFault        (electrical_fault_flag),
        .mecFault       (mechanical_fault_flag),
        .hotFault       (over_temperature_flag),
        .busTimeout     (busTimeout),
        .comError       (comError),
        .measField      (measField),
        .classCode      (classCode),
        .mfrCode        (mfrCode),
        .slaveNoResp    (slaveNoResp),
        .checksumFault  (checksumFault),
        .idParityFault  (idParityFault),
        .syncBreakFault (syncBreakFault),
        .respByte       (respByte)
    );

    // Response bytes; control frames never get an answer
    always_comb
    begin
        nxt_txIdx   = txIdx_ff;
        nxt_txByte  = txByte_ff;
        nxt_txValid = 1'b0;
        evSent      = 1'b0;
        if (frmStart)
            nxt_txIdx = 2'h0;
        else if (txReq && (kind_ff == RLPM_K_STAT || kind_ff == RLPM_K_IDENT)
                 && txIdx_ff < `RLPM_RESP_BYTES) // RULE12
        begin
            nxt_txByte  = respByte; // RULE7
            nxt_txValid = 1'b1;
            nxt_txIdx   = txIdx_ff + 2'h1;
            evSent      = txIdx_ff == `RLPM_RESP_BYTES - 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txIdx_ff   <= 2'h0;
            txByte_ff  <= 8'h00;
            txValid_ff <= 1'b0;
        end
        else
        begin
            txIdx_ff   <= nxt_txIdx;
            txByte_ff  <= nxt_txByte;
            txValid_ff <= nxt_txValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port, sticky events and interrupt
    assign events = {4'h0, evSent, ctrlOk && nxt_shut, ctrlBad, ctrlOk};

    always_comb
    begin
        nxt_mask   = mask_ff;
        nxt_cfg    = cfg_ff;
        nxt_rdData = 8'h00;
        // Set wins over a same-cycle write-one clear
        nxt_stat = stat_ff;
        if (regWr && regAddr == `RLPM_A_IRQ_STAT)
            nxt_stat = stat_ff & ~regWdata;
        nxt_stat = nxt_stat | events;
        if (regWr && regAddr == `RLPM_A_IRQ_MASK)
            nxt_mask = regWdata;
        if (regWr && regAddr == `RLPM_A_CFG)
            nxt_cfg = regWdata;
        if (regRd)
        begin
            unique case (regAddr)
                `RLPM_A_IRQ_STAT: nxt_rdData = stat_ff;
                `RLPM_A_IRQ_MASK: nxt_rdData = mask_ff;
                `RLPM_A_CFG:      nxt_rdData = cfg_ff;
                `RLPM_A_TV:       nxt_rdData = {shut_ff, preExc_ff, tv_ff};
                `RLPM_A_RAMP:     nxt_rdData = {rc_ff, rr_ff};
                `RLPM_A_CLIM:     nxt_rdData = {3'h0, cl_ff};
                default:          nxt_rdData = 8'h00;
            endcase
        end
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_ff   <= 8'h00;
            mask_ff   <= `RLPM_MASK_RST;
            cfg_ff    <= `RLPM_CFG_RST;
            rdData_ff <= 8'h00;
            irq_ff    <= 1'b0;
        end
        else
        begin
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            cfg_ff    <= nxt_cfg;
            rdData_ff <= nxt_rdData;
            irq_ff    <= nxt_irq;
        end
    end

    // Outputs straight from registers
    assign txByte                = txByte_ff;
    assign txValid               = txValid_ff;
    assign targetVoltage         = tv_ff;
    assign setting_a             = rc_ff;
    assign load_response_control = rr_ff;
    assign currentLimit          = cl_ff;
    assign preExcEnable          = preExc_ff;
    assign shutdownCmd           = shut_ff;
    assign regRdata              = rdData_ff;
    assign irq                   = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_CTRL_B: assert property (frmStart && frmId == `RLPM_ID_CTRL_B // RULE2
        && cfg_ff[`RLPM_CFG_ALT_B] |=> kind_ff == RLPM_K_CTRL)
        else $error("B control id not taken");
    AST_STAT_A: assert property (frmStart && frmId == `RLPM_ID_STAT_A // RULE6
        && !cfg_ff[`RLPM_CFG_ALT_B] |=> kind_ff == RLPM_K_STAT)
        else $error("A status id not taken");
    AST_IDENT_A: assert property (frmStart && frmId == `RLPM_ID_IDENT_A // RULE9
        && !cfg_ff[`RLPM_CFG_ALT_B] |=> kind_ff == RLPM_K_IDENT)
        else $error("A identifier id not taken");
    AST_TV_DECODE: assert property (ctrlOk |=> targetVoltage == $past(rxBuf_ff[0][5:0])) // RULE3
        else $error("target voltage decode wrong");
    AST_RAMP_DECODE: assert property (ctrlOk |=> setting_a == $past(rxBuf_ff[1][7:4]) // RULE4
        && load_response_control == $past(rxBuf_ff[1][3:0]))
        else $error("ramp decode wrong");
    AST_CLIM_DECODE: assert property (ctrlOk |=> currentLimit == $past(rxBuf_ff[2][4:0])) // RULE5
        else $error("current limit decode wrong");
    AST_HOLD_BAD: assert property (ctrlBad && !ctrlOk |=> $stable(targetVoltage) // RULE15
        && $stable(currentLimit) && $stable(preExcEnable))
        else $error("settings changed on bad frame");
    AST_NO_CTRL_TX: assert property (kind_ff == RLPM_K_CTRL && !frmStart |=> !txValid) // RULE12
        else $error("control frame answered");
    AST_SHUTDOWN: assert property (ctrlOk && rxBuf_ff[0][5:0] == 6'h00 // RULE13
        |=> shutdownCmd && !preExcEnable)
        else $error("zero code did not shut down");
    AST_STAT_B1: assert property (txReq && !frmStart && kind_ff == RLPM_K_STAT // RULE7
        && txIdx_ff == 2'h0 |=> txValid && txByte == {$past(excitation_duty_cycle),
        $past(electrical_fault_flag), $past(mechanical_fault_flag),
        $past(over_temperature_flag)})
        else $error("status byte 1 wrong");
    AST_STAT_B2: assert property (txReq && !frmStart && kind_ff == RLPM_K_STAT // RULE8
        && txIdx_ff == 2'h1 |=> txByte[7] == $past(busTimeout)
        && txByte[6] == $past(comError))
        else $error("status byte 2 wrong");
    AST_MEAS_CLAMP: assert property (txReq && !frmStart && kind_ff == RLPM_K_STAT // RULE14
        && txIdx_ff == 2'h1 && !cfg_ff[`RLPM_CFG_TEMP] && measCurrent > 8'h3F
        |=> txByte[5:0] == 6'h3F)
        else $error("current not clamped");
    AST_ID_B1: assert property (txReq && !frmStart && kind_ff == RLPM_K_IDENT // RULE10
        && txIdx_ff == 2'h0 |=> txByte == {$past(classCode), $past(mfrCode)})
        else $error("identifier byte 1 wrong");
    AST_ID_B2: assert property (txReq && !frmStart && kind_ff == RLPM_K_IDENT // RULE11
        && txIdx_ff == 2'h1 |=> txByte[7:4] == 4'h0 && txByte[0] == $past(syncBreakFault))
        else $error("identifier byte 2 wrong");

    COV_ACCEPT:   cover property (ctrlOk ##1 preExcEnable);
    COV_SHUTDOWN: cover property (ctrlOk ##1 shutdownCmd);
    COV_STATUS:   cover property (txValid ##1 txValid && kind_ff == RLPM_K_STAT);
    COV_IRQ:      cover property (ctrlBad ##[1:3] irq);
endmodule : rlpm_payload_map
`default_nettype wire

// ---- verif/rlpm_lin_master.sv ----
// LIN master model: frame strobes, control payloads, response polling
`timescale 1ns/1ps
`default_nettype none
module rlpm_lin_master
(
    input  wire logic       core_clk,
    input  wire logic [7:0] txByte,
    input  wire logic       txValid,
    output logic            frmStart,
    output logic [5:0]      frmId,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            frmDone,
    output logic            frmChkErr,
    output logic            frmParErr,
    output logic            txReq
);
    logic [7:0] seen[$];   // Response bytes caught, cleared per poll

    ////////////////////////////////////////////////////////////////////////
    // Quiet link at time zero
    initial
    begin
        {frmStart, rxValid, frmDone, frmChkErr, frmParErr, txReq} = 6'h00;
        frmId  = 6'h00;
        rxByte = 8'h00;
    end

    // Registered pulses, so sampling on the edge sees last cycle's value
    always @(posedge core_clk)
        if (txValid === 1'b1)
            seen.push_back(txByte);

    ////////////////////////////////////////////////////////////////////////
    // Control frame, master to slave; upper don't-care bits sent as given
    task automatic sendCtrl(input logic [5:0] id, input logic [31:0] data, input int nBytes,
                            input logic chk, input logic par);
        @(posedge core_clk);
        frmStart <= 1'b1;
        frmId    <= id;
        for (int i = 0; i < nBytes; i++)
        begin
            @(posedge core_clk);
            frmStart <= 1'b0;
            rxValid  <= 1'b1;
            rxByte   <= data[31 - 8 * i -: 8];
        end
        @(posedge core_clk);
        frmStart  <= 1'b0;
        rxValid   <= 1'b0;
        rxByte    <= ~rxByte;   // Released lines never keep the last value
        frmId     <= ~frmId;
        frmDone   <= 1'b1;
        frmChkErr <= chk;
        frmParErr <= par;
        @(posedge core_clk);
        {frmDone, frmChkErr, frmParErr} <= 3'h0;
    endtask : sendCtrl

    // Header then three back-to-back byte requests; a third must be refused
    task automatic pollResp(input logic [5:0] id);
        seen.delete();
        @(posedge core_clk);
        frmStart <= 1'b1;
        frmId    <= id;
        @(posedge core_clk);
        frmStart <= 1'b0;
        frmId    <= ~frmId;
        txReq    <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(posedge core_clk);
        txReq   <= 1'b0;
        frmDone <= 1'b1;
        @(posedge core_clk);
        frmDone <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : pollResp
endmodule : rlpm_lin_master
`default_nettype wire

// ---- verif/tb_rlpm_payload_map.sv ----
// Self-checking testbench of the LIN payload decoder and packer
`timescale 1ns/1ps
`default_nettype none
module tb_rlpm_payload_map;
    import rlpm_pkg::*;
    logic core_clk, rst_n, frmStart, rxValid, frmDone, frmChkErr, frmParErr, txReq, txValid;
    logic [5:0] frmId, measTemp, targetVoltage;
    logic [7:0] rxByte, measCurrent, regWdata, txByte, regRdata;
    logic [4:0] duty, classCode, currentLimit;
    logic [2:0] mfrCode;
    logic [3:0] regAddr, cutoff, rate;
    logic el, mec, hot, busTimeout, comError, noResp, chkF, parF, syncF;
    logic regWr, regRd, preExcEnable, shutdownCmd, irq;
    int errCount, comparisons;

    rlpm_lin_master m (.core_clk(core_clk), .txByte(txByte), .txValid(txValid),
        .frmStart(frmStart), .frmId(frmId), .rxValid(rxValid), .rxByte(rxByte),
        .frmDone(frmDone), .frmChkErr(frmChkErr), .frmParErr(frmParErr), .txReq(txReq));

    rlpm_payload_map DUT (.core_clk(core_clk), .rst_n(rst_n), .frmStart(frmStart),
        .frmId(frmId), .rxValid(rxValid), .rxByte(rxByte), .frmDone(frmDone),
        .frmChkErr(frmChkErr), .frmParErr(frmParErr), .txReq(txReq),
        .excitation_duty_cycle(duty), .electrical_fault_flag(el),
        .mechanical_fault_flag(mec), .over_temperature_flag(hot), .busTimeout(busTimeout),
        .comError(comError), .measCurrent(measCurrent), .measTemp(measTemp),
        .classCode(classCode), .mfrCode(mfrCode), .slaveNoResp(noResp),
        .checksumFault(chkF), .idParityFault(parF), .syncBreakFault(syncF),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .txByte(txByte), .txValid(txValid), .targetVoltage(targetVoltage),
        .setting_a(cutoff), .load_response_control(rate), .currentLimit(currentLimit),
        .preExcEnable(preExcEnable), .shutdownCmd(shutdownCmd), .regRdata(regRdata),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////
    // Register port: one-cycle strobes, read data only in the next cycle
    task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask : regRead

    task automatic settle;
        @(posedge core_clk);
        #1;
    endtask : settle

    task automatic checkResp(input int n, input logic [7:0] b1, input logic [7:0] b2);
        check(8'(m.seen.size()), 8'(n));
        if (n == 2)
        begin
            check(m.seen[0], b1);
            check(m.seen[1], b2);
        end
    endtask : checkResp

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic tReset;
        check(8'(preExcEnable), 8'h00);
        check(8'(irq), 8'h00);
        regRead(4'h1, 8'h00);
        regRead(4'h2, 8'h00);
        $display("test reset done");
    endtask : tReset

    task automatic tCtrlA;
        regWrite(4'h1, 8'h07);
        m.sendCtrl(6'h29, 32'hC5A7FF5A, 4, 1'b0, 1'b0);
        settle();
        check(8'(targetVoltage), 8'h05);
        check(8'(cutoff), 8'h0A);
        check(8'(rate), 8'h07);
        check(8'(currentLimit), 8'h1F);
        check(8'({preExcEnable, shutdownCmd, irq}), 8'h05);
        regRead(4'h0, 8'h01);
        regWrite(4'h0, 8'h01);
        regWrite(4'h3, 8'hFF);   // Read-only place, write must vanish
        settle();
        check(8'(irq), 8'h00);
        regRead(4'h3, 8'h45);
        regRead(4'h4, 8'hA7);
        regRead(4'hA, 8'h00);
        $display("test control A done");
    endtask : tCtrlA

    task automatic tReject;
        m.sendCtrl(6'h29, 32'h00000000, 4, 1'b1, 1'b0);
        m.sendCtrl(6'h29, 32'h00000000, 4, 1'b0, 1'b1);
        m.sendCtrl(6'h29, 32'h00000000, 3, 1'b0, 1'b0);
        settle();
        check(8'({shutdownCmd, targetVoltage}), 8'h05);
        check(8'(irq), 8'h01);
        regRead(4'h0, 8'h02);
        regWrite(4'h0, 8'hFF);
        $display("test reject done");
    endtask : tReject

    task automatic tStatus;
        duty        <= 5'h15;
        {el, mec, hot, busTimeout, comError} <= 5'b10110;
        measCurrent <= 8'h80;
        m.pollResp(6'h11);
        checkResp(2, 8'hAD, 8'hBF);
        regRead(4'h0, 8'h08);
        regWrite(4'h2, 8'h02);
        {el, mec, hot, busTimeout, comError} <= 5'b01101;
        measTemp    <= 6'h2A;
        m.pollResp(6'h11);
        checkResp(2, 8'hAB, 8'h6A);
        $display("test status done");
    endtask : tStatus

    task automatic tIdent;
        classCode <= 5'h13;
        mfrCode   <= 3'h5;
        {noResp, chkF, parF, syncF} <= 4'b1011;
        m.pollResp(6'h12);
        checkResp(2, 8'h9D, 8'h0B);
        m.pollResp(6'h29);
        checkResp(0, 8'h00, 8'h00);
        $display("test ident done");
    endtask : tIdent

    task automatic tAltB;
        regWrite(4'h2, 8'h01);
        m.sendCtrl(6'h29, 32'h01112233, 4, 1'b0, 1'b0);
        settle();
        check(8'(targetVoltage), 8'h05);
        m.sendCtrl(6'h2A, 32'hC05BE300, 4, 1'b0, 1'b0);
        settle();
        check(8'({cutoff, rate}), 8'h5B);
        check(8'({shutdownCmd, preExcEnable, targetVoltage}), 8'h80);
        check(8'(currentLimit), 8'h03);
        m.pollResp(6'h13);
        checkResp(2, 8'hAB, 8'h7F);
        regRead(4'h0, 8'h0F);
        regRead(4'h5, 8'h03);
        $display("test alternator B done");
    endtask : tAltB

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; every input has a value at time zero
    initial
    begin
        core_clk = 1'b0;
        rst_n    = 1'b0;
        {regWr, regRd, regAddr, regWdata} = '0;
        {duty, el, mec, hot, busTimeout, comError, measCurrent, measTemp} = '0;
        {classCode, mfrCode, noResp, chkF, parF, syncF} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        tReset();
        tCtrlA();
        tReject();
        tStatus();
        tIdent();
        tAltB();
        conclude();
    end

    // Watchdog, far beyond the hundred-odd cycles the run needs
    initial
    begin
        #(50 * 3000);
        errCount++;
        conclude();
    end
endmodule : tb_rlpm_payload_map
`default_nettype wire
